/* File: srxr_lane_invert.sv */
// srxr_lane_invert: registered optional inversion of one lane's deserialized data
`timescale 1ns/1ps
module srxr_lane_invert #(
	parameter int W = 32
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// lane data
	input wire logic invert,
	input wire logic [W-1:0] lane_in,
	output logic [W-1:0] lane_out
);

	// flip every bit when this lane's mask bit is set
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			lane_out <= '0;
		end else begin
			lane_out <= invert ? ~lane_in : lane_in;
		end
	end

	AST_LANE_INVERT: assert property (@(posedge clk) disable iff (sys_rst)
		1'b1 |=> lane_out == ($past(invert) ? ~$past(lane_in) : $past(lane_in)))
		else $error("lane output does not follow inversion mask");

endmodule

/* File: srxr_pkg.sv */
// srxr_pkg: shared constants, register indices and carrier types of the receive register bank
package srxr_pkg;

	// ==================================================
	// sizes
	localparam int NUM_LANES = 8;
	localparam int LANE_W = 32;
	localparam int SAMPLE_W = 16;
	localparam int NUM_CONV = 4;
	localparam int NUM_SLOT = 16;
	localparam int ADDR_W = 16;
	localparam int IDX_W = 12;

	// ==================================================
	// register indices (byte address is four times the index)
	localparam logic [11:0] IDX_CMP_CTRL = 12'h32c;
	localparam logic [11:0] IDX_REF_LOW = 12'h32d;
	localparam logic [11:0] IDX_REF_HIGH = 12'h32e;
	localparam logic [11:0] IDX_CMP_RESULT = 12'h32f;
	localparam logic [11:0] IDX_IRQ_STATUS = 12'h330;
	localparam logic [11:0] IDX_IRQ_MASK = 12'h331;
	localparam logic [11:0] IDX_INVERT = 12'h334;
	localparam logic [11:0] IDX_DEV_IDENT = 12'h400;
	localparam logic [11:0] IDX_BANK_IDENT = 12'h401;
	localparam logic [11:0] IDX_LANE_ADJ = 12'h402;
	localparam logic [11:0] IDX_SCR_LANES = 12'h403;
	localparam logic [11:0] IDX_OCTETS = 12'h404;
	localparam logic [11:0] IDX_FRAMES = 12'h405;

	// ==================================================
	// field positions
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_CLR_BIT = 1;
	localparam int CTRL_DAC_LSB = 2;
	localparam int CTRL_SLOT_LSB = 4;
	localparam int STAT_MISMATCH_BIT = 0;
	localparam int STAT_CFG_BIT = 1;
	localparam int LANE_ADJDIR_BIT = 6;
	localparam int LANE_PHADJ_BIT = 5;
	localparam int SCR_FLAG_BIT = 7;

	// ==================================================
	// reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;

	// ==================================================
	// carriers
	typedef struct packed {
		logic [7:0] device_ident;
		logic [7:0] bank_ident;
		logic adjust_dir;
		logic phase_req;
		logic [4:0] lane_ident;
		logic scramble;
		logic [4:0] lanes_m1;
		logic [7:0] octets_m1;
		logic [4:0] frames_m1;
	} srxr_ilas_cfg_t;

	// msb first, so the packed order matches the control byte layout
	typedef struct packed {
		logic [3:0] slot_sel;
		logic [1:0] dac_sel;
		logic clear;
		logic enable;
	} srxr_cmp_ctrl_t;

	typedef enum logic [0:0] {
		SRXR_PH_WAIT = 1'b0,
		SRXR_PH_ANSWER = 1'b1
	} srxr_apb_phase_t;

endpackage

/* File: srxr_regs.sv */
// srxr_regs: apb register bank for lane inversion, sample test and received link config
`timescale 1ns/1ps

// Function
// - read/write reference sample low byte
// - read/write reference sample high byte
// - compare reference with selected received sample
// - result bit 0: 1 mismatch, rest zero
// - eight-bit lane inversion mask, reset zero
// - mask bit n inverts lane n
// - capture received device identifier, read-only
// - capture received bank identifier, read-only
// - bit 6 holds received adjust direction
// - bit 5 phase request, bit 7 reserved
// - bits 4..0 hold received lane identifier
// - bit 7 holds received scrambling flag
// - bits 4..0 hold lanes count minus one
// - octets per frame minus one, read-only
// - config only from lane 0, reset zero
// - compare only when enabled; clear resets result
// - frames per multiframe minus one, five bits
module srxr_regs (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [srxr_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// interrupt
	output logic irq,
	// deserialized lanes in and out
	input wire logic [srxr_pkg::NUM_LANES*srxr_pkg::LANE_W-1:0] lane_data_in,
	output logic [srxr_pkg::NUM_LANES*srxr_pkg::LANE_W-1:0] lane_data_out,
	// transport samples for the short test
	input wire logic sample_valid,
	input wire logic [srxr_pkg::NUM_CONV*srxr_pkg::NUM_SLOT*srxr_pkg::SAMPLE_W-1:0] samples,
	// alignment configuration decoded from lane 0
	input wire logic lane0_cfg_done,
	input wire srxr_pkg::srxr_ilas_cfg_t lane0_cfg,
	// test result
	output logic sample_compare_mismatch
);

	// ==================================================
	// declarations
	srxr_pkg::srxr_apb_phase_t phase;
	srxr_pkg::srxr_cmp_ctrl_t cmp_ctrl;
	srxr_pkg::srxr_ilas_cfg_t cfg;
	logic [7:0] expected_sample_low_byte;
	logic [7:0] expected_sample_high_byte;
	logic [7:0] lane_invert_bits;
	logic [7:0] irq_status;
	logic [7:0] irq_mask;
	logic [srxr_pkg::IDX_W-1:0] idx;
	logic access;
	logic done;
	logic wr_done;
	logic rd_done;
	logic mapped;
	logic [7:0] next_rdata;
	logic fail_now;
	logic fail_prev;
	logic mismatch_event;

	// ==================================================
	// apb decode
	assign idx = paddr[srxr_pkg::IDX_W+1:2];
	assign access = psel && penable;
	assign done = access && pready;
	assign wr_done = done && pwrite;
	assign rd_done = done && !pwrite;

	// read mux, unmapped indices read zero and raise an error
	always_comb begin
		next_rdata = srxr_pkg::RST_BYTE;
		mapped = 1'b1;
		case (idx)
			srxr_pkg::IDX_CMP_CTRL: begin
				next_rdata = cmp_ctrl;
			end
			srxr_pkg::IDX_REF_LOW: begin
				next_rdata = expected_sample_low_byte;
			end
			srxr_pkg::IDX_REF_HIGH: begin
				next_rdata = expected_sample_high_byte;
			end
			srxr_pkg::IDX_CMP_RESULT: begin
				next_rdata = {7'b000_0000, fail_now};
			end
			srxr_pkg::IDX_IRQ_STATUS: begin
				next_rdata = irq_status;
			end
			srxr_pkg::IDX_IRQ_MASK: begin
				next_rdata = irq_mask;
			end
			srxr_pkg::IDX_INVERT: begin
				next_rdata = lane_invert_bits;
			end
			srxr_pkg::IDX_DEV_IDENT: begin
				next_rdata = cfg.device_ident;
			end
			srxr_pkg::IDX_BANK_IDENT: begin
				next_rdata = cfg.bank_ident;
			end
			srxr_pkg::IDX_LANE_ADJ: begin
				// reserved top bit, direction, phase request, lane identifier
				next_rdata = {1'b0, cfg.adjust_dir, cfg.phase_req, cfg.lane_ident};
			end
			srxr_pkg::IDX_SCR_LANES: begin
				next_rdata = {cfg.scramble, 2'b00, cfg.lanes_m1};
			end
			srxr_pkg::IDX_OCTETS: begin
				next_rdata = cfg.octets_m1;
			end
			srxr_pkg::IDX_FRAMES: begin
				next_rdata = {3'b000, cfg.frames_m1};
			end
			default: begin
				mapped = 1'b0;
			end
		endcase
	end

	// ==================================================
	// apb answer: one wait state, then ready with data
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			phase <= srxr_pkg::SRXR_PH_WAIT;
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= srxr_pkg::RST_WORD;
		end else begin
			case (phase)
				srxr_pkg::SRXR_PH_WAIT: begin
					if (access) begin
						phase <= srxr_pkg::SRXR_PH_ANSWER;
						pready <= 1'b1;
						pslverr <= !mapped;
						prdata <= pwrite ? srxr_pkg::RST_WORD : {24'h00_0000, next_rdata};
					end
				end
				srxr_pkg::SRXR_PH_ANSWER: begin
					phase <= srxr_pkg::SRXR_PH_WAIT;
					pready <= 1'b0;
					pslverr <= 1'b0;
				end
				default: begin
					phase <= srxr_pkg::SRXR_PH_WAIT;
					pready <= 1'b0;
				end
			endcase
		end
	end

	// ==================================================
	// writable registers, taken at the completing edge only
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			expected_sample_low_byte <= srxr_pkg::RST_BYTE;
			expected_sample_high_byte <= srxr_pkg::RST_BYTE;
			lane_invert_bits <= srxr_pkg::RST_BYTE;
			cmp_ctrl <= srxr_pkg::RST_BYTE;
			irq_mask <= srxr_pkg::RST_BYTE;
		end else if (wr_done) begin
			case (idx)
				srxr_pkg::IDX_REF_LOW: expected_sample_low_byte <= pwdata[7:0];
				srxr_pkg::IDX_REF_HIGH: expected_sample_high_byte <= pwdata[7:0];
				srxr_pkg::IDX_INVERT: lane_invert_bits <= pwdata[7:0];
				srxr_pkg::IDX_CMP_CTRL: cmp_ctrl <= pwdata[7:0];
				srxr_pkg::IDX_IRQ_MASK: irq_mask <= pwdata[7:0];
				default: begin
				end
			endcase
		end
	end

	// ==================================================
	// received link configuration, lane 0 only, read-only
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cfg <= '0;
		end else if (lane0_cfg_done) begin
			cfg <= lane0_cfg;
		end
	end

	// ==================================================
	// short transport test
	srxr_sample_compare u_compare (
		.clk(clk),
		.sys_rst(sys_rst),
		.ctrl(cmp_ctrl),
		.reference({expected_sample_high_byte, expected_sample_low_byte}),
		.sample_valid(sample_valid),
		.samples(samples),
		.sample_compare_mismatch(fail_now)
	);

	// ==================================================
	// per lane inversion, mask bit n on logical lane n
	genvar g;
	generate
		for (g = 0; g < srxr_pkg::NUM_LANES; g++) begin : gen_lane
			srxr_lane_invert #(
				.W(srxr_pkg::LANE_W)
			) u_inv (
				.clk(clk),
				.sys_rst(sys_rst),
				.invert(lane_invert_bits[g]),
				.lane_in(lane_data_in[g*srxr_pkg::LANE_W +: srxr_pkg::LANE_W]),
				.lane_out(lane_data_out[g*srxr_pkg::LANE_W +: srxr_pkg::LANE_W])
			);
		end
	endgenerate

	// ==================================================
	// result output and failure edge
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			fail_prev <= 1'b0;
			sample_compare_mismatch <= 1'b0;
		end else begin
			fail_prev <= fail_now;
			sample_compare_mismatch <= fail_now;
		end
	end
	assign mismatch_event = fail_now && !fail_prev;

	// ==================================================
	// sticky status, cleared by reading it; a new event wins
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			irq_status <= srxr_pkg::RST_BYTE;
		end else begin
			// clear only the bits the read returned, an event during the read survives
			if (rd_done && idx == srxr_pkg::IDX_IRQ_STATUS) begin
				irq_status <= irq_status & ~prdata[7:0];
			end
			if (mismatch_event) begin
				irq_status[srxr_pkg::STAT_MISMATCH_BIT] <= 1'b1;
			end
			if (lane0_cfg_done) begin
				irq_status[srxr_pkg::STAT_CFG_BIT] <= 1'b1;
			end
		end
	end

	// level interrupt from unmasked status
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_status & irq_mask);
		end
	end

	// ==================================================
	// checks
	sequence s_access_start;
		psel && penable && !pready;
	endsequence

	sequence s_answer;
		pready ##1 !pready;
	endsequence

	AST_APB_ANSWER: assert property (@(posedge clk) disable iff (sys_rst)
		s_access_start |=> s_answer)
		else $error("apb answer not given after one wait cycle");

	AST_REF_LOW_WRITE: assert property (@(posedge clk) disable iff (sys_rst)
		wr_done && idx == srxr_pkg::IDX_REF_LOW
		|=> expected_sample_low_byte == $past(pwdata[7:0]))
		else $error("reference low byte not written");

	AST_REF_HIGH_WRITE: assert property (@(posedge clk) disable iff (sys_rst)
		wr_done && idx == srxr_pkg::IDX_REF_HIGH
		|=> expected_sample_high_byte == $past(pwdata[7:0]))
		else $error("reference high byte not written");

	AST_RESULT_READ: assert property (@(posedge clk) disable iff (sys_rst)
		access && !pready && !pwrite && idx == srxr_pkg::IDX_CMP_RESULT
		|=> prdata == {31'h0000_0000, $past(fail_now)})
		else $error("result register read wrong");

	AST_INVERT_WRITE: assert property (@(posedge clk) disable iff (sys_rst)
		wr_done && idx == srxr_pkg::IDX_INVERT
		|=> lane_invert_bits == $past(pwdata[7:0]))
		else $error("inversion mask not written");

	AST_CFG_CAPTURE: assert property (@(posedge clk) disable iff (sys_rst)
		lane0_cfg_done |=> cfg == $past(lane0_cfg))
		else $error("lane 0 configuration not captured");

	AST_CFG_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
		!lane0_cfg_done |=> $stable(cfg))
		else $error("captured configuration changed without a sequence");

	AST_LANE_READ: assert property (@(posedge clk) disable iff (sys_rst)
		access && !pready && !pwrite && idx == srxr_pkg::IDX_LANE_ADJ
		|=> prdata[7:5] == {1'b0, $past(cfg.adjust_dir), $past(cfg.phase_req)})
		else $error("lane identifier register read wrong");

	AST_IRQ_LEVEL: assert property (@(posedge clk) disable iff (sys_rst)
		|(irq_status & irq_mask) |=> irq)
		else $error("interrupt not raised for unmasked status");

	AST_CTRL_WRITE: assert property (@(posedge clk) disable iff (sys_rst)
		wr_done && idx == srxr_pkg::IDX_CMP_CTRL
		|=> cmp_ctrl == $past(pwdata[7:0]))
		else $error("compare control not written");

	AST_RESULT_OUT: assert property (@(posedge clk) disable iff (sys_rst)
		1'b1 |=> sample_compare_mismatch == $past(fail_now))
		else $error("result output does not follow result bit");

	AST_SCR_READ: assert property (@(posedge clk) disable iff (sys_rst)
		access && !pready && !pwrite && idx == srxr_pkg::IDX_SCR_LANES
		|=> prdata[7:0] == {$past(cfg.scramble), 2'b00, $past(cfg.lanes_m1)})
		else $error("scramble and lane count register read wrong");

	AST_UNMAPPED_ERR: assert property (@(posedge clk) disable iff (sys_rst)
		access && !pready && !mapped
		|=> pready && pslverr)
		else $error("unmapped access did not answer with an error");

	AST_MISMATCH_STATUS: assert property (@(posedge clk) disable iff (sys_rst)
		mismatch_event |=> irq_status[srxr_pkg::STAT_MISMATCH_BIT])
		else $error("new mismatch did not set its status bit");

	AST_CFG_STATUS: assert property (@(posedge clk) disable iff (sys_rst)
		lane0_cfg_done |=> irq_status[srxr_pkg::STAT_CFG_BIT])
		else $error("configuration capture did not set its status bit");

endmodule

/* File: srxr_regs_test.sv */
// srxr_regs_test: self-checking bench for the receive register bank
`timescale 1ns/1ps
module srxr_regs_test;
	logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, irq;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [255:0] lane_in, lane_out;
	logic sample_valid, cfg_done, mism, send_cfg;
	logic [1023:0] samples;
	srxr_pkg::srxr_ilas_cfg_t cfg, cfg_in;
	logic [15:0] fill;
	logic [6:0] pick;
	logic [4:0] l;
	int n_fail = 0;
	int n_checks = 0;
	int cyc = 0;
	logic [11:0] idx_tab [12] = '{12'h32c, 12'h32d, 12'h32e, 12'h32f, 12'h330, 12'h331,
		12'h334, 12'h400, 12'h401, 12'h402, 12'h403, 12'h404};

	srxr_regs srxr_regs_inst (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .lane_data_in(lane_in), .lane_data_out(lane_out),
		.sample_valid(sample_valid), .samples(samples), .lane0_cfg_done(cfg_done),
		.lane0_cfg(cfg), .sample_compare_mismatch(mism));
	srxr_tx_model srxr_tx_model_inst (.clk(clk), .sys_rst(sys_rst), .fill(fill), .pick(pick),
		.send_cfg(send_cfg), .cfg_in(cfg_in), .lane_data(lane_in),
		.sample_valid(sample_valid), .samples(samples), .cfg_done(cfg_done), .cfg(cfg));

	// ==================================================
	// clock and hang guard
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			final_report();
		end
	end

	// ==================================================
	// tasks
	task final_report;
		if (n_fail == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task chk_wide(input logic [255:0] got, input logic [255:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one apb transfer, then one idle cycle
	task apb(input logic w, input logic [11:0] idx, input logic [7:0] d,
		output logic [31:0] r, output logic e);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= {24'h00_0000, d};
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task wr(input logic [11:0] idx, input logic [7:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, idx, d, r, e);
	endtask
	// read compare, error response shown as bit 31
	task rd(input logic [11:0] idx, input logic [31:0] exp);
		logic [31:0] r;
		logic e;
		apb(1'b0, idx, 8'h00, r, e);
		chk(r | {e, 31'h0}, exp);
	endtask
	task chk_lanes(input logic [7:0] m);
		logic [255:0] li, ex;
		@(posedge clk);
		#1 li = lane_in;
		@(posedge clk);
		#1;
		for (int n = 0; n < 8; n++) ex[32*n +: 32] = li[32*n +: 32] ^ {32{m[n]}};
		chk_wide(lane_out, ex);
		@(posedge clk);
	endtask
	task send(input srxr_pkg::srxr_ilas_cfg_t v);
		send_cfg <= 1'b1;
		cfg_in <= v;
		@(posedge clk);
		send_cfg <= 1'b0;
		repeat (3) @(posedge clk);
	endtask

	// ==================================================
	// main sequence
	initial begin
		sys_rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 16'h0000;
		pwdata = 32'h0000_0000;
		fill = 16'h0000;
		pick = 7'h7f;
		send_cfg = 1'b0;
		cfg_in = '0;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		foreach (idx_tab[i]) rd(idx_tab[i], 32'h0000_0000);
		chk({30'h0, irq, mism}, 32'h0000_0000);
		// read/write bytes, read-only and unmapped places
		wr(12'h32d, 8'h34);
		wr(12'h32e, 8'h12);
		wr(12'h334, 8'ha5);
		wr(12'h400, 8'hff);
		wr(12'h32f, 8'hff);
		rd(12'h32d, 32'h0000_0034);
		rd(12'h32e, 32'h0000_0012);
		rd(12'h334, 32'h0000_00a5);
		rd(12'h400, 32'h0000_0000);
		rd(12'h32f, 32'h0000_0000);
		rd(12'h3ff, 32'h8000_0000);
		chk_lanes(8'ha5);
		// sample test: converter 2 slot 5, neighbour wrong first
		fill <= 16'h1234;
		pick <= 7'd38;
		wr(12'h32c, 8'h59);
		repeat (4) @(posedge clk);
		rd(12'h32f, 32'h0000_0000);
		pick <= 7'd37;
		repeat (4) @(posedge clk);
		rd(12'h32f, 32'h0000_0001);
		chk({31'h0, mism}, 32'h0000_0001);
		wr(12'h331, 8'h01);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h0000_0001);
		rd(12'h330, 32'h0000_0001);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h0000_0000);
		wr(12'h32c, 8'h5b);
		rd(12'h32f, 32'h0000_0000);
		wr(12'h32c, 8'h58);
		rd(12'h32c, 32'h0000_0058);
		repeat (4) @(posedge clk);
		rd(12'h32f, 32'h0000_0000);
		// config capture over lane counts 1, 2, 4 and 8 and both frame counts
		for (int i = 0; i < 4; i++) begin
			l = 5'((1 << i) - 1);
			send({8'h5a, 8'hc3, 1'b1, 1'b0, 5'h13, i[0], l, 8'h03, i[0] ? 5'h1f : 5'h0f});
			rd(12'h403, {24'h00_0000, i[0], 2'b00, l});
			rd(12'h405, i[0] ? 32'h0000_001f : 32'h0000_000f);
		end
		rd(12'h400, 32'h0000_005a);
		rd(12'h401, 32'h0000_00c3);
		rd(12'h402, 32'h0000_0053);
		rd(12'h403, 32'h0000_0087);
		rd(12'h404, 32'h0000_0003);
		rd(12'h330, 32'h0000_0002);
		chk({31'h0, irq}, 32'h0000_0000);
		final_report();
	end
endmodule

/* File: srxr_sample_compare.sv */
// srxr_sample_compare: short transport test, one selected sample against a reference
`timescale 1ns/1ps
module srxr_sample_compare (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// control
	input wire srxr_pkg::srxr_cmp_ctrl_t ctrl,
	input wire logic [srxr_pkg::SAMPLE_W-1:0] reference,
	// received samples, converter major, slot minor
	input wire logic sample_valid,
	input wire logic [srxr_pkg::NUM_CONV*srxr_pkg::NUM_SLOT*srxr_pkg::SAMPLE_W-1:0] samples,
	// result
	output logic sample_compare_mismatch
);

	logic [5:0] pick;
	logic [srxr_pkg::SAMPLE_W-1:0] chosen;

	// select converter and slot
	assign pick = {ctrl.dac_sel, ctrl.slot_sel};
	assign chosen = samples[pick*srxr_pkg::SAMPLE_W +: srxr_pkg::SAMPLE_W];

	// result is held until the clear control resets it
	always_ff @(posedge clk) begin
		if (sys_rst || ctrl.clear) begin
			sample_compare_mismatch <= 1'b0;
		end else if (ctrl.enable && sample_valid && chosen != reference) begin
			sample_compare_mismatch <= 1'b1;
		end
	end

	AST_MISMATCH_SETS: assert property (@(posedge clk) disable iff (sys_rst)
		ctrl.enable && !ctrl.clear && sample_valid && chosen != reference
		|=> sample_compare_mismatch)
		else $error("mismatching sample did not flag failure");

	AST_IDLE_HOLDS: assert property (@(posedge clk) disable iff (sys_rst)
		!ctrl.enable && !ctrl.clear |=> $stable(sample_compare_mismatch))
		else $error("result changed while test disabled");

endmodule

/* File: srxr_tx_model.sv */
// srxr_tx_model: behavioural link transmitter driving lanes, samples and lane 0 config
`timescale 1ns/1ps
module srxr_tx_model (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// bench controls
	input wire logic [15:0] fill,
	input wire logic [6:0] pick,
	input wire logic send_cfg,
	input wire srxr_pkg::srxr_ilas_cfg_t cfg_in,
	// link side
	output logic [255:0] lane_data,
	output logic sample_valid,
	output logic [1023:0] samples,
	output logic cfg_done,
	output srxr_pkg::srxr_ilas_cfg_t cfg
);
	logic [7:0] cnt;

	// ==================================================
	// lane words change every cycle, lane number in the top byte
	always_ff @(posedge clk) begin
		cnt <= sys_rst ? 8'h00 : cnt + 8'h01;
		for (int n = 0; n < 8; n++) begin
			lane_data[32*n +: 32] <= {8'(n), cnt, ~cnt, cnt ^ 8'h5a};
		end
	end

	// every sample carries fill, the picked one its inverse
	always_comb begin
		sample_valid = 1'b1;
		for (int i = 0; i < 64; i++) begin
			samples[16*i +: 16] = (7'(i) == pick) ? ~fill : fill;
		end
	end

	// config only valid in the done cycle, scrambled otherwise to expose stale capture
	always_ff @(posedge clk) begin
		cfg_done <= sys_rst ? 1'b0 : send_cfg;
		cfg <= sys_rst ? '0 : (send_cfg ? cfg_in : ~cfg);
	end
endmodule
